//--- adcseq_top.sv
// converter sequencing: wishbone registers, prescaler, conversion timing
//
// The Wishbone interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/100ps
module adcseq_top
    import adcseq_pkg::*;
#(
    parameter int TRIG_N = 4   // number of auto-trigger sources
)(
    // clock and reset
    input  wire logic                 mclk,
    input  wire logic                 reset_n,
    input  wire logic                 clk_en,
    // wishbone slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [3:0]           wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    // trigger and sleep inputs from the core, same clock
    input  wire logic [TRIG_N-1:0]    trig_src,
    input  wire logic [1:0]           trig_select,
    input  wire logic                 sleep_quiet_entry,
    // analog converter side
    input  wire logic [RES_W-1:0]     analog_result,
    output logic                      sample_hold,
    output logic [SEL_W-1:0]          active_select,
    output logic                      conv_irq_req
);
    // the two-bit trigger select decodes at most four sources
    if (TRIG_N < 1 || TRIG_N > 4) begin : g_bad_trig_n
        $error("TRIG_N must be 1 to 4");
    end

    adcseq_presc_if pif();

    // software-visible state
    logic             en_q, start_q, auto_q, done_q, ie_q;
    logic [2:0]       div_q;
    logic [SEL_W-1:0] sel_buf_q;
    logic [SEL_W-1:0] sel_act_q;
    logic [RES_W-1:0] result_q;
    // sequencing state
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CONV} adcseq_state_e;
    adcseq_state_e    st_q;
    adcseq_kind_e     kind_q;
    logic             first_q;
    logic [5:0]       half_q;
    logic [1:0]       sync_q;
    logic             trig_prev_q;
    logic             irq_q, sh_q, ack_q;
    logic [31:0]      dat_q;

    logic             wr, ctrl_wr, dis_wr;
    logic             trig_lvl, trig_rise, finish, sleep_go;
    logic [5:0]       total_half, sh_half;

    // a write lands at the edge where the master samples ack, never earlier
    assign wr      = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && wb_sel_i[0];
    assign ctrl_wr = wr && (wb_adr_i == ADCSEQ_OFS_CTRL);
    assign dis_wr  = ctrl_wr && !wb_dat_i[CTL_EN];
    assign pif.run     = en_q;
    assign pif.restart = (sync_q == 2'(TRIG_SYNC_CYC - 1));
    assign pif.div_sel = div_q;

    adcseq_presc u_presc (
        .mclk    (mclk),
        .reset_n (reset_n),
        .clk_en  (clk_en),
        .p       (pif)
    );

    // per-kind length and hold point in half converter cycles
    function automatic logic [5:0] kind_len(input adcseq_kind_e k, input logic hold);
        case (k)
            KIND_FIRST: kind_len = hold ? SH_FIRST  : HALF_FIRST;
            KIND_AUTO:  kind_len = hold ? SH_AUTO   : HALF_AUTO;
            KIND_FREE:  kind_len = hold ? SH_FREE   : HALF_FREE;
            default:    kind_len = hold ? SH_NORMAL : HALF_NORMAL;
        endcase
    endfunction : kind_len

    assign total_half = kind_len(kind_q, 1'b0);
    assign sh_half    = kind_len(kind_q, 1'b1);
    assign trig_lvl   = trig_src[trig_select[$clog2(TRIG_N > 1 ? TRIG_N : 2)-1:0] % TRIG_N];
    assign trig_rise  = trig_lvl && !trig_prev_q;
    assign finish     = (st_q == ST_CONV) && pif.half_tick && (half_q == total_half - 6'h01);
    // quiet sleep entry starts a single conversion when idle
    assign sleep_go   = sleep_quiet_entry && en_q && !auto_q && ie_q && st_q == ST_IDLE
                        && !start_q;

    // trigger edge detection, clean same-clock source
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) trig_prev_q <= 1'b0;
        else if (clk_en) trig_prev_q <= trig_lvl;
    end

    // three-cycle trigger synchroniser; edges during conversion ignored
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sync_q <= 2'h0;
        end else if (clk_en) begin
            if (sync_q != 2'h0) begin
                sync_q <= (sync_q == 2'(TRIG_SYNC_CYC - 1)) ? 2'h0 : sync_q + 2'h1;
            end else if (trig_rise && en_q && auto_q && st_q == ST_IDLE && !done_q) begin
                sync_q <= 2'h1;
            end
        end
    end

    // control register; hardware start and completion win over software clear
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            en_q <= 1'b0; start_q <= 1'b0; auto_q <= 1'b0;
            done_q <= 1'b0; ie_q <= 1'b0; div_q <= 3'h0;
        end else if (clk_en) begin
            if (wr && wb_adr_i == ADCSEQ_OFS_CTRL) begin
                en_q   <= wb_dat_i[CTL_EN];
                auto_q <= wb_dat_i[CTL_AUTO];
                ie_q   <= wb_dat_i[CTL_IE];
                div_q  <= wb_dat_i[CTL_DIV_W-1:0];
                if (wb_dat_i[CTL_START] && wb_dat_i[CTL_EN]) start_q <= 1'b1;
                if (wb_dat_i[CTL_DONE] && !finish) done_q <= 1'b0;   // write one clears
                if (!wb_dat_i[CTL_EN]) start_q <= 1'b0;
            end
            if (sleep_go || pif.restart) start_q <= 1'b1;
            if (finish) begin
                done_q <= 1'b1;
                // start stays high only when free running carries straight on
                start_q <= auto_q && (trig_select == 2'h0);
            end
        end
    end

    // conversion sequencer: a single start waits for a converter clock rise; a trigger
    // starts at once, since the divider restarts in the same cycle
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_q    <= ST_IDLE;
            kind_q  <= KIND_NORMAL;
            first_q <= 1'b1;
            half_q  <= 6'h00;
        end else if (clk_en) begin
            // a disabling write idles at once so start and state never disagree
            if (!en_q || dis_wr) begin
                st_q    <= ST_IDLE;
                first_q <= 1'b1;
            end else begin
                case (st_q)
                    ST_IDLE: begin
                        if (pif.restart) begin
                            st_q    <= ST_CONV;
                            half_q  <= 6'h00;
                            kind_q  <= first_q ? KIND_FIRST : KIND_AUTO;
                            first_q <= 1'b0;
                        end else if (start_q || sleep_go) begin
                            st_q <= ST_WAIT;
                        end
                    end
                    ST_WAIT: begin
                        if (pif.rise) begin
                            st_q    <= ST_CONV;
                            half_q  <= 6'h00;
                            kind_q  <= first_q ? KIND_FIRST : KIND_NORMAL;
                            first_q <= 1'b0;
                        end
                    end
                    ST_CONV: begin
                        if (pif.half_tick) half_q <= half_q + 6'h01;
                        if (finish) begin
                            if (auto_q && trig_select == 2'h0) begin
                                st_q   <= ST_CONV;
                                half_q <= 6'h00;
                                kind_q <= KIND_FREE;
                            end else begin
                                st_q <= ST_IDLE;
                            end
                        end
                    end
                    default: st_q <= ST_IDLE;
                endcase
            end
        end
    end

    // selection buffer, random access by software
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) sel_buf_q <= SEL_RESET;
        else if (clk_en && wr && wb_adr_i == ADCSEQ_OFS_SEL) sel_buf_q <= wb_dat_i[SEL_W-1:0];
    end

    // active selection follows buffer outside conversions and in the last cycle
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sel_act_q <= SEL_RESET;
        end else if (clk_en) begin
            if (st_q != ST_CONV || half_q >= total_half - 6'h02)
                sel_act_q <= sel_buf_q;   // free-run restart keeps the lock
        end
    end

    // result capture, sample pulse, interrupt request
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            result_q <= '0; sh_q <= 1'b0; irq_q <= 1'b0;
        end else if (clk_en) begin
            sh_q  <= (st_q == ST_CONV) && pif.half_tick && (half_q == sh_half - 6'h01);
            irq_q <= done_q && ie_q;   // request held regardless of wake source
            if (finish) result_q <= analog_result;
        end
    end

    // wishbone answer, one cycle after request, unmapped reads zero
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ack_q <= 1'b0; dat_q <= 32'h0000_0000;
        end else if (clk_en) begin
            ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
            case (wb_adr_i)
                ADCSEQ_OFS_CTRL:   dat_q <= {24'h00_0000, en_q, start_q, auto_q, done_q,
                                             ie_q, div_q};
                ADCSEQ_OFS_SEL:    dat_q <= {24'h00_0000, sel_buf_q};
                ADCSEQ_OFS_RESULT: dat_q <= {22'h00_0000, result_q};
                ADCSEQ_OFS_STAT:   dat_q <= {28'h000_0000, first_q, 1'b0, st_q};
                default:           dat_q <= 32'h0000_0000;
            endcase
        end
    end

    // sleep modes other than quiet ones have no input here, so enable is untouched
    assign wb_ack_o      = ack_q;
    assign wb_dat_o      = dat_q;
    assign sample_hold   = sh_q;
    assign active_select = sel_act_q;
    assign conv_irq_req  = irq_q;

    a_start_busy : assert property (@(posedge mclk) disable iff (!reset_n)
        (st_q == ST_CONV && !finish) |-> start_q) else $error("start low in conversion");
    a_done_sets : assert property (@(posedge mclk) disable iff (!reset_n)
        (finish && clk_en) |=> done_q) else $error("flag not set");
    a_single_clear : assert property (@(posedge mclk) disable iff (!reset_n)
        (finish && clk_en && !auto_q && !wr) |=> !start_q) else $error("start not cleared");
    a_sel_locked : assert property (@(posedge mclk) disable iff (!reset_n)
        (st_q == ST_CONV && $past(st_q) == ST_CONV && half_q < 6'h02 && half_q != 6'h00)
        |-> $stable(sel_act_q)) else $error("selection moved");
    a_trig_sync : assert property (@(posedge mclk) disable iff (!reset_n)
        (sync_q == 2'h1 && clk_en) |=> ##[0:40] pif.restart) else $error("no restart");
    a_wait_rise : assert property (@(posedge mclk) disable iff (!reset_n)
        (st_q == ST_WAIT && pif.rise && en_q && clk_en) |=> st_q == ST_CONV)
        else $error("no start on rise");
    a_disable_idle : assert property (@(posedge mclk) disable iff (!reset_n)
        (!en_q && clk_en) |=> (st_q == ST_IDLE && first_q)) else $error("not idle after disable");
    a_ack_pulse : assert property (@(posedge mclk) disable iff (!reset_n)
        ack_q && clk_en |=> !ack_q) else $error("ack held");
endmodule : adcseq_top

//--- adcseq_pkg.sv
// shared constants for the converter sequencing block
package adcseq_pkg;
    // register byte offsets on the wishbone bus
    localparam logic [3:0] ADCSEQ_OFS_CTRL   = 4'h0;   // converter_control_status
    localparam logic [3:0] ADCSEQ_OFS_SEL    = 4'h4;   // channel_reference_select
    localparam logic [3:0] ADCSEQ_OFS_RESULT = 4'h8;   // conversion result
    localparam logic [3:0] ADCSEQ_OFS_STAT   = 4'hC;   // status
    // control field positions
    localparam int CTL_EN    = 7;
    localparam int CTL_START = 6;
    localparam int CTL_AUTO  = 5;
    localparam int CTL_DONE  = 4;
    localparam int CTL_IE    = 3;
    localparam int CTL_DIV_W = 3;   // clock_divide_select width at bits 2:0
    // selection field layout
    localparam int SEL_CH_W  = 6;   // input_channel_field bits 5:0
    localparam int SEL_REF_W = 2;   // reference_source_field bits 7:6
    localparam int SEL_W     = SEL_CH_W + SEL_REF_W;
    localparam logic [7:0] SEL_RESET = 8'h00;
    // converter clock counts, in half cycles of the converter clock
    localparam logic [5:0] HALF_FIRST    = 6'h32;   // 25 cycles
    localparam logic [5:0] HALF_NORMAL   = 6'h1A;   // 13 cycles
    localparam logic [5:0] HALF_AUTO     = 6'h1B;   // 13.5 cycles
    localparam logic [5:0] HALF_FREE     = 6'h1C;   // 14 cycles
    localparam logic [5:0] SH_FIRST      = 6'h1B;   // 13.5
    localparam logic [5:0] SH_NORMAL     = 6'h03;   // 1.5
    localparam logic [5:0] SH_AUTO       = 6'h04;   // 2
    localparam logic [5:0] SH_FREE       = 6'h05;   // 2.5
    localparam int TRIG_SYNC_CYC = 3;   // cpu cycles spent synchronising a trigger
    localparam int RES_W = 10;
    typedef enum logic [1:0] {KIND_FIRST, KIND_NORMAL, KIND_AUTO, KIND_FREE} adcseq_kind_e;
endpackage : adcseq_pkg

//--- adcseq_presc_if.sv
// carrier between sequencer and prescaler
`timescale 1ns/100ps
interface adcseq_presc_if;
    logic       run;       // converter enabled
    logic       restart;   // trigger reset of the divider
    logic [2:0] div_sel;   // clock_divide_select
    logic       half_tick; // every half converter clock
    logic       rise;      // converter clock rising edge
    modport ctrl (output run, output restart, output div_sel, input half_tick, input rise);
    modport presc(input run, input restart, input div_sel, output half_tick, output rise);
endinterface : adcseq_presc_if

//--- adcseq_presc.sv
// power-of-two prescaler producing converter clock half-cycle ticks
`timescale 1ns/100ps
module adcseq_presc
    import adcseq_pkg::*;
(
    // clocking
    input  wire logic mclk,
    input  wire logic reset_n,
    input  wire logic clk_en,
    // sequencer side
    adcseq_presc_if.presc p
);
    logic [7:0] cnt_q;
    logic       phase_q;
    logic [7:0] half_len;

    // half period is 2^(sel-1) cpu cycles; sel 0 still divides by 2
    always_comb begin
        half_len = 8'h01 << ((p.div_sel == 3'h0) ? 3'h0 : (p.div_sel - 3'h1));
    end

    // divider held in reset while disabled, restarted on a trigger
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q   <= 8'h00;
            phase_q <= 1'b0;
        end else if (clk_en) begin
            if (!p.run || p.restart) begin
                cnt_q   <= 8'h00;
                phase_q <= 1'b0;
            end else if (cnt_q >= half_len - 8'h01) begin
                cnt_q   <= 8'h00;
                phase_q <= ~phase_q;
            end else begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end

    // greater-or-equal so a smaller ratio written mid-count does not wrap the counter
    assign p.half_tick = clk_en && p.run && !p.restart && (cnt_q >= half_len - 8'h01);
    assign p.rise      = p.half_tick && phase_q;

    a_presc_reset : assert property (@(posedge mclk) disable iff (!reset_n)
        (!p.run && clk_en) |=> (cnt_q == 8'h00)) else $error("prescaler ran while disabled");
endmodule : adcseq_presc

//--- adcseq_core_model.sv
// core-side model: auto-trigger source flags and converter data path
`timescale 1ns/100ps
module adcseq_core_model #(
    parameter int TRIG_N = 4
)(
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              reset_n,
    // bench requests
    input  wire logic              fire,
    input  wire logic [1:0]        fire_idx,
    input  wire logic [7:0]        hold_len,
    input  wire logic [9:0]        level,
    // towards the design
    output logic      [TRIG_N-1:0] trig_src,
    output logic      [9:0]        analog_result
);
    logic [7:0] left_q;
    // a flag stays set hold_len + 1 cycles, like a timer flag that software clears late
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            left_q   <= 8'h00;
            trig_src <= '0;
        end else if (fire) begin
            left_q             <= hold_len;
            trig_src[fire_idx] <= 1'b1;
        end else if (left_q != 8'h00) begin
            left_q <= left_q - 8'h01;
        end else begin
            trig_src <= '0;
        end
    end
    // converter output held steady so a captured word can be predicted
    always_ff @(posedge mclk) begin
        analog_result <= level;
    end
endmodule : adcseq_core_model

//--- tb_adcseq_top.sv
// self-checking bench for the converter sequencing block
`timescale 1ns/100ps
module tb_adcseq_top;
    import adcseq_pkg::*;
    localparam int LIMIT = 20000;   // cycles; the whole sequence needs well under half
    logic        mclk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, sleep_quiet_entry, fire;
    logic [3:0]  wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, rdat;
    logic        wb_ack_o, sample_hold, conv_irq_req, irq_q;
    logic [1:0]  trig_select, fire_idx;
    logic [3:0]  trig_src;
    logic [9:0]  analog_result;
    logic [7:0]  active_select;
    int          num_errors = 0, comparisons = 0, cycle = 0, t_ack, t0, n0, h0;
    int          hold_cyc = 0, prev_hold = 0, done_cyc = 0, n_hold = 0, n_done = 0;

    adcseq_top i_dut (.mclk(mclk), .reset_n(reset_n), .clk_en(1'b1), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'h1),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .trig_src(trig_src),
        .trig_select(trig_select), .sleep_quiet_entry(sleep_quiet_entry),
        .analog_result(analog_result), .sample_hold(sample_hold),
        .active_select(active_select), .conv_irq_req(conv_irq_req));
    adcseq_core_model i_core (.mclk(mclk), .reset_n(reset_n), .fire(fire), .fire_idx(fire_idx),
        .hold_len(8'h28), .level(10'h2A5), .trig_src(trig_src), .analog_result(analog_result));

    // clock, 40 ns period
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // cycle count and timestamps of hold pulses and completion requests
    always @(posedge mclk) begin
        cycle <= cycle + 1;
        irq_q <= conv_irq_req;
        if (sample_hold === 1'b1) begin
            hold_cyc  <= cycle;
            prev_hold <= hold_cyc;
            n_hold    <= n_hold + 1;
        end
        if (conv_irq_req === 1'b1 && irq_q !== 1'b1) begin
            done_cyc <= cycle;
            n_done   <= n_done + 1;
        end
    end
    // hang guard
    initial begin
        repeat (LIMIT) @(posedge mclk);
        num_errors++;
        print_verdict();
    end

    task automatic print_verdict;
        if (num_errors == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_rng(input int v, input int lo, input int hi);
        comparisons++;
        if (v < lo || v > hi) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
        end
    endtask : chk_rng
    // classic single cycle; request held until ack is sampled high
    task automatic wb_xfer(input logic we, input logic [3:0] a, input logic [31:0] wd);
        @(posedge mclk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= wd;
        do @(posedge mclk); while (wb_ack_o !== 1'b1);
        rdat  = wb_dat_o;
        t_ack = cycle;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb_xfer
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        wb_xfer(1'b1, a, d);
    endtask : wr
    task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
        wb_xfer(1'b0, a, 32'h0000_0000);
        chk(rdat, exp);
    endtask : rdc
    // wait for the next completion, then check hold point and hold-to-done span
    task automatic wait_conv(input int n, input int base, input int lo, input int hi, input int gap);
        while (n_done == n) @(posedge mclk);
        chk_rng(hold_cyc - base, lo, hi);
        chk_rng(done_cyc - hold_cyc, gap - 1, gap + 1);
    endtask : wait_conv

    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, sleep_quiet_entry, fire} = 5'h00;
        {wb_adr_i, wb_dat_i, trig_select, fire_idx} = '0;
        reset_n = 1'b0;
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        // reset values, unmapped address
        rdc(ADCSEQ_OFS_CTRL, 32'h0000_0000);
        rdc(ADCSEQ_OFS_SEL, 32'h0000_0000);
        wr(4'h2, 32'h0000_00FF);
        rdc(4'h2, 32'h0000_0000);
        rdc(ADCSEQ_OFS_CTRL, 32'h0000_0000);
        // start while disabled: divider held, nothing converts
        wr(ADCSEQ_OFS_CTRL, 32'h0000_0043);
        repeat (100) @(posedge mclk);
        chk(n_hold, 0);
        // first conversion at divide 128, about 195 kHz, inside the full-resolution band
        wr(ADCSEQ_OFS_SEL, 32'h0000_0045);
        n0 = n_done;
        wr(ADCSEQ_OFS_CTRL, 32'h0000_00CF);
        t0 = t_ack;
        // more than one converter clock after the start before touching the selection
        repeat (140) @(posedge mclk);
        wr(ADCSEQ_OFS_SEL, 32'h0000_0092);
        chk(active_select, 8'h45);
        rdc(ADCSEQ_OFS_CTRL, 32'h0000_00CF);
        wait_conv(n0, t0, 1727, 1858, 1472);
        rdc(ADCSEQ_OFS_RESULT, 32'h0000_02A5);
        rdc(ADCSEQ_OFS_CTRL, 32'h0000_009F);
        chk(active_select, 8'h92);
        // reference changed above, so software would drop that word
        wr(ADCSEQ_OFS_CTRL, 32'h0000_009F);
        // normal conversions across every divide ratio
        for (int s = 1; s < 8; s++) begin
            n0 = n_done;
            wr(ADCSEQ_OFS_CTRL, 32'h0000_00C8 | s);
            wait_conv(n0, t_ack, (3 << s) / 2 - 1, (5 << s) / 2 + 2, (23 << s) / 2);
            wr(ADCSEQ_OFS_CTRL, 32'h0000_0098 | s);
        end
        // auto trigger, second edge mid-conversion must be ignored
        trig_select <= 2'h1;
        wr(ADCSEQ_OFS_CTRL, 32'h0000_00AB);
        n0 = n_done;
        h0 = n_hold;
        @(posedge mclk);
        fire     <= 1'b1;
        fire_idx <= 2'h1;
        t0 = cycle;
        @(posedge mclk);
        fire <= 1'b0;
        repeat (60) @(posedge mclk);
        // well past one converter clock after the trigger, so only the next one sees it
        wr(ADCSEQ_OFS_SEL, 32'h0000_0003);
        chk(active_select, 8'h92);
        fire <= 1'b1;
        @(posedge mclk);
        fire <= 1'b0;
        wait_conv(n0, t0, 17, 24, 92);
        repeat (200) @(posedge mclk);
        chk(n_hold - h0, 1);
        chk(active_select, 8'h03);
        wr(ADCSEQ_OFS_CTRL, 32'h0000_009B);
        // free running
        trig_select <= 2'h0;
        wr(ADCSEQ_OFS_CTRL, 32'h0000_00EB);
        n0 = n_hold;
        while (n_hold < n0 + 3) @(posedge mclk);
        chk_rng(hold_cyc - prev_hold, 112, 112);
        rdc(ADCSEQ_OFS_CTRL, 32'h0000_00FB);
        wr(ADCSEQ_OFS_CTRL, 32'h0000_0000);
        repeat (20) @(posedge mclk);
        wr(ADCSEQ_OFS_CTRL, 32'h0000_0010);
        // sleep start after re-enable, early wake before completion
        wr(ADCSEQ_OFS_CTRL, 32'h0000_008B);
        n0 = n_done;
        @(posedge mclk);
        sleep_quiet_entry <= 1'b1;
        t0 = cycle;
        repeat (30) @(posedge mclk);
        sleep_quiet_entry <= 1'b0;
        wait_conv(n0, t0, 107, 120, 92);
        print_verdict();
    end
endmodule : tb_adcseq_top
